//--- core/mcr_pkg.sv
// mode request and mode status package: bus carrier, register map, mode codes, timing
// assumes a single 20 MHz clock mclk and a synchronous active-high reset
// Function
// - request code 111 moves the controller into accept-all-messages mode
// - request code 100 moves the controller into configuration mode
// - codes 011, 010, 001 select listen-only, loopback and disable
// - status field reads 111 while in accept-all-messages mode
// - status field reads 100 while in configuration mode
// - status field reads 011 in listen-only and 010 in loopback
package mcr_pkg;

  localparam int MCLK_NS = 50;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MODE_STAT = 4'h1;

  // control register one field positions
  localparam int STOP_IDLE_BIT = 13;
  localparam int REQ_LSB = 8;
  localparam int MODE_LSB = 5;
  localparam int CAPTURE_BIT = 3;
  localparam int WINDOW_BIT = 0;

  // mode status register field positions
  localparam int PEND_BIT = 0;
  localparam int REJ_BIT = 1;

  localparam logic STOP_IDLE_RST = 1'b0;
  localparam logic CAPTURE_RST = 1'b0;
  localparam logic WINDOW_RST = 1'b0;
  localparam logic REJ_RST = 1'b0;

  typedef enum logic [2:0] {
    MCR_NORMAL      = 3'b000,
    MCR_DISABLE     = 3'b001,
    MCR_LOOPBACK    = 3'b010,
    MCR_LISTEN_ONLY = 3'b011,
    MCR_CONFIG      = 3'b100,
    MCR_RSVD_A      = 3'b101,
    MCR_RSVD_B      = 3'b110,
    MCR_LISTEN_ALL  = 3'b111
  } mcr_mode_t;

  localparam mcr_mode_t MODE_RST = MCR_CONFIG;

  // quiet time on the bus before a new mode is committed
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC_I = (SETTLE_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int SETTLE_W = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_CYC_I[SETTLE_W-1:0];

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } mcr_bus_t;

  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic accept_all;
    logic loopback;
    logic config_open;
    logic disabled;
  } mcr_ctl_t;

endpackage

//--- core/mcr_settle_timer.sv
// settle timer: counts a loaded number of mclk cycles and pulses done once
// assumes start is a one-cycle pulse and abort wins over start
`timescale 1ns/1ps
module mcr_settle_timer #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] load,
  output logic done
);

  typedef struct packed {
    logic run;
    logic [W-1:0] cnt;
    logic done;
  } mcr_tmr_t;

  mcr_tmr_t s;
  mcr_tmr_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (abort) begin
      next_s.run = 1'b0;
    end else if (start) begin
      next_s.run = 1'b1;
      next_s.cnt = load;
    end else if (s.run) begin
      if (s.cnt <= W'(1)) begin
        next_s.run = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

endmodule // mcr_settle_timer

//--- core/mcr_mode_fsm.sv
// mode transition engine: holds the entered mode and commits a new request once
// the bus has been quiet for the settle time
// assumes frame_active is high for the whole of any frame on the bus
`timescale 1ns/1ps
module mcr_mode_fsm
  import mcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire mcr_mode_t req,
  input wire logic frame_active,
  output mcr_mode_t cur_mode,
  output logic busy
);

  typedef enum logic [1:0] {
    MCR_ST_IDLE   = 2'b00,
    MCR_ST_WAIT   = 2'b01,
    MCR_ST_SETTLE = 2'b10
  } mcr_fsm_st_t;

  typedef struct packed {
    mcr_fsm_st_t st;
    mcr_mode_t mode;
  } mcr_fsm_t;

  mcr_fsm_t s;
  mcr_fsm_t next_s;
  logic tmr_start;
  logic tmr_abort;
  logic tmr_done;

  always_comb begin
    next_s = s;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    unique case (s.st)
      MCR_ST_IDLE: begin
        if (req != s.mode) begin
          next_s.st = MCR_ST_WAIT;
        end
      end
      MCR_ST_WAIT: begin
        if (req == s.mode) begin
          next_s.st = MCR_ST_IDLE;
        end else if (!frame_active) begin
          tmr_start = 1'b1;
          next_s.st = MCR_ST_SETTLE;
        end
      end
      MCR_ST_SETTLE: begin
        // a frame that starts now must finish before the switch, never be cut
        if (frame_active || req == s.mode) begin
          tmr_abort = 1'b1;
          next_s.st = MCR_ST_WAIT;
        end else if (tmr_done) begin
          next_s.mode = req;
          next_s.st = MCR_ST_IDLE;
        end
      end
      default: begin
        next_s.st = MCR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s.st <= MCR_ST_IDLE;
      s.mode <= MODE_RST;
    end else begin
      s <= next_s;
    end
  end

  mcr_settle_timer #(
    .W(SETTLE_W)
  ) u_settle (
    .mclk(mclk),
    .rst(rst),
    .start(tmr_start),
    .abort(tmr_abort),
    .load(SETTLE_CYC),
    .done(tmr_done)
  );

  assign cur_mode = s.mode;
  assign busy = (s.st != MCR_ST_IDLE);

endmodule // mcr_mode_fsm

//--- core/mcr_mode_ctrl.sv
// operating mode control: control register one, mode status register, mode decode
// assumes a plain register port with read data one cycle after the read strobe
`timescale 1ns/1ps
module mcr_mode_ctrl
  import mcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire mcr_bus_t bus,
  output logic [DATA_W-1:0] rdata,
  input wire logic frame_active,
  output mcr_ctl_t ctl,
  output logic stop_in_idle,
  output logic capture_enable,
  output logic filter_window
);

  typedef struct packed {
    mcr_mode_t req;
    logic stop_idle;
    logic capture;
    logic window;
    logic rej;
    mcr_ctl_t ctl;
    logic [DATA_W-1:0] rdata;
  } mcr_top_t;

  mcr_top_t s;
  mcr_top_t next_s;
  mcr_mode_t cur_mode;
  logic busy;
  logic wr_ctrl;
  logic wr_stat;
  logic rsvd_req;
  mcr_mode_t wr_req;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] stat_word;

  mcr_mode_fsm u_fsm (
    .mclk(mclk),
    .rst(rst),
    .req(s.req),
    .frame_active(frame_active),
    .cur_mode(cur_mode),
    .busy(busy)
  );

  assign wr_ctrl = bus.we && (bus.addr == ADDR_CTRL_ONE);
  assign wr_stat = bus.we && (bus.addr == ADDR_MODE_STAT);
  assign wr_req = mcr_mode_t'(bus.wdata[REQ_LSB +: 3]);
  // reserved codes are dropped so the engine never chases an undefined mode
  assign rsvd_req = (wr_req == MCR_RSVD_A) || (wr_req == MCR_RSVD_B);

  always_comb begin
    ctrl_word = '0;
    ctrl_word[STOP_IDLE_BIT] = s.stop_idle;
    ctrl_word[REQ_LSB +: 3] = s.req;
    ctrl_word[MODE_LSB +: 3] = cur_mode;
    ctrl_word[CAPTURE_BIT] = s.capture;
    ctrl_word[WINDOW_BIT] = s.window;
    stat_word = '0;
    stat_word[PEND_BIT] = busy;
    stat_word[REJ_BIT] = s.rej;
  end

  always_comb begin
    next_s = s;
    if (wr_ctrl) begin
      next_s.stop_idle = bus.wdata[STOP_IDLE_BIT];
      next_s.capture = bus.wdata[CAPTURE_BIT];
      next_s.window = bus.wdata[WINDOW_BIT];
      if (!rsvd_req) begin
        next_s.req = wr_req;
      end
    end
    // write one clears the sticky flag; a new rejection in that cycle wins
    if (wr_stat && bus.wdata[REJ_BIT]) begin
      next_s.rej = 1'b0;
    end
    if (wr_ctrl && rsvd_req) begin
      next_s.rej = 1'b1;
    end
    next_s.rdata = '0;
    if (bus.re) begin
      if (bus.addr == ADDR_CTRL_ONE) begin
        next_s.rdata = ctrl_word;
      end else if (bus.addr == ADDR_MODE_STAT) begin
        next_s.rdata = stat_word;
      end
    end
    // engine outputs follow the entered mode, never the request
    next_s.ctl = '0;
    unique case (cur_mode)
      MCR_NORMAL: begin
        next_s.ctl.tx_enable = 1'b1;
        next_s.ctl.rx_enable = 1'b1;
      end
      MCR_DISABLE: begin
        next_s.ctl.disabled = 1'b1;
      end
      MCR_LOOPBACK: begin
        next_s.ctl.tx_enable = 1'b1;
        next_s.ctl.rx_enable = 1'b1;
        next_s.ctl.loopback = 1'b1;
      end
      MCR_LISTEN_ONLY: begin
        next_s.ctl.rx_enable = 1'b1;
      end
      MCR_CONFIG: begin
        next_s.ctl.config_open = 1'b1;
      end
      MCR_LISTEN_ALL: begin
        next_s.ctl.rx_enable = 1'b1;
        next_s.ctl.accept_all = 1'b1;
      end
      default: begin
        next_s.ctl.disabled = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s.req <= MODE_RST;
      s.stop_idle <= STOP_IDLE_RST;
      s.capture <= CAPTURE_RST;
      s.window <= WINDOW_RST;
      s.rej <= REJ_RST;
      s.ctl <= '0;
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign ctl = s.ctl;
  assign stop_in_idle = s.stop_idle;
  assign capture_enable = s.capture;
  assign filter_window = s.window;

endmodule // mcr_mode_ctrl

//--- tb/mcr_mode_ctrl_monitor.sv
// monitor: mode decode, settle and read port checks at the control block ports
// assumes it is bound into mcr_mode_ctrl and sees only its ports
`timescale 1ns/1ps
module mcr_mode_ctrl_monitor
  import mcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire mcr_bus_t bus,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic frame_active,
  input wire mcr_ctl_t ctl
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // quiet cycles before a switch: settle count plus the wait, start and commit stages
  localparam int QUIET_MIN = SETTLE_CYC_I + 3;
  logic [7:0] quiet;
  always_ff @(posedge mclk) begin
    if (rst || frame_active) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hff) begin
      quiet <= quiet + 8'h01;
    end
  end
  // ctl lags the entered mode by a cycle, so the decode may show one edge late
  sequence s_rd_mode(logic [2:0] m);
    $past(bus.re) && $past(bus.addr) == ADDR_CTRL_ONE && rdata[7:5] == m;
  endsequence
  property p_all; s_rd_mode(3'b111) |-> ##[0:1] ctl == 6'h18; endproperty
  property p_cfg; s_rd_mode(3'b100) |-> ##[0:1] ctl == 6'h02; endproperty
  property p_listen; s_rd_mode(3'b011) |-> ##[0:1] ctl == 6'h10; endproperty
  property p_loop; s_rd_mode(3'b010) |-> ##[0:1] ctl == 6'h34; endproperty
  property p_excl;
    $onehot0({ctl.accept_all, ctl.loopback, ctl.config_open, ctl.disabled});
  endproperty
  property p_settle;
    !$past(rst) && !$past(rst, 2) && !$stable(ctl) |-> quiet >= QUIET_MIN;
  endproperty
  property p_rd_idle; !$past(bus.re) |-> rdata == '0; endproperty
  a_all: assert property (p_all) else $error("listen-all decode wrong");
  a_cfg: assert property (p_cfg) else $error("config decode wrong");
  a_listen: assert property (p_listen) else $error("listen-only decode wrong");
  a_loop: assert property (p_loop) else $error("loopback decode wrong");
  a_excl: assert property (p_excl) else $error("two modes at once");
  a_settle: assert property (p_settle) else $error("mode changed on busy bus");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule // mcr_mode_ctrl_monitor

//--- tb/mcr_can_node.sv
// partner: another node putting a frame of len cycles on the bus
// assumes start is sampled each edge; a held start just reloads the length
`timescale 1ns/1ps
module mcr_can_node (
  input wire logic mclk,
  input wire logic start,
  input wire logic [7:0] len,
  output logic frame_active
);
  logic [7:0] left = 8'h00;
  assign frame_active = left != 8'h00;
  always @(posedge mclk) begin
    if (start) begin
      left <= len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule // mcr_can_node

//--- tb/tb.sv
// testbench: mode requests over the register port, reserved codes, busy bus
// assumes mcr_mode_ctrl as top, the can node model beside it, monitor bound below
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  import mcr_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  mcr_bus_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic frame_active, stop_in_idle, capture_enable, filter_window;
  logic fstart = 1'b0;
  logic re_d = 1'b0;
  logic [7:0] flen = 8'h00;
  mcr_ctl_t ctl;
  logic [15:0] expq[$];
  logic [15:0] e, o;
  logic [2:0] cur, c;
  logic [2:0] codes [6] = '{3'b111, 3'b011, 3'b010, 3'b001, 3'b000, 3'b100};
  int miscompares = 0;
  int n_compared = 0;
  always #25 mclk = ~mclk;
  mcr_mode_ctrl mcr_mode_ctrl_inst (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .frame_active(frame_active), .ctl(ctl), .stop_in_idle(stop_in_idle),
    .capture_enable(capture_enable), .filter_window(filter_window));
  mcr_can_node mcr_can_node_inst (.mclk(mclk), .start(fstart), .len(flen),
    .frame_active(frame_active));
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one strobe cycle, then an idle cycle, so no signal is driven twice per edge
  task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, we: w, re: !w};
    @(posedge mclk);
    bus <= '0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] x);
    expq.push_back(x);
    acc(1'b0, a, 16'h0000);
  endtask
  function automatic logic [15:0] cr(logic [2:0] b, logic [2:0] req, logic [2:0] m);
    return {2'b00, b[0], 2'b00, req, m, 1'b0, b[1], 2'b00, b[2]};
  endfunction
  function automatic mcr_ctl_t ctl_of(logic [2:0] m);
    case (m)
      3'b111: return 6'h18;
      3'b100: return 6'h02;
      3'b011: return 6'h10;
      3'b010: return 6'h34;
      3'b001: return 6'h01;
      default: return 6'h30;
    endcase
  endfunction
  // read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (re_d) begin
      e = expq.pop_front();
      `CHK("rdata", e, rdata)
    end
    re_d <= bus.re;
  end
  initial begin
    void'($urandom(32'he57ac8b2));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    cur = 3'b100;
    rd(ADDR_CTRL_ONE, 16'h0480);
    rd(ADDR_MODE_STAT, 16'h0000);
    acc(1'b1, 4'h7, 16'hffff);
    rd(4'h7, 16'h0000);
    rd(ADDR_CTRL_ONE, 16'h0480);
    $display("test reset and unmapped done");
    foreach (codes[i]) begin
      c = codes[i];
      o = 16'($urandom);
      acc(1'b1, ADDR_CTRL_ONE, cr(o[2:0], c, 3'b000));
      rd(ADDR_CTRL_ONE, cr(o[2:0], c, cur));
      rd(ADDR_MODE_STAT, 16'h0001);
      repeat (14) @(posedge mclk);
      rd(ADDR_CTRL_ONE, cr(o[2:0], c, c));
      `CHK("ctl", ctl_of(c), ctl)
      `CHK("misc", {o[0], o[1], o[2]}, {stop_in_idle, capture_enable, filter_window})
      cur = c;
    end
    $display("test mode codes done");
    for (int k = 6; k >= 5; k--) begin
      acc(1'b1, ADDR_CTRL_ONE, cr(3'b000, 3'(k), 3'b000));
      rd(ADDR_CTRL_ONE, cr(3'b000, cur, cur));
      rd(ADDR_MODE_STAT, 16'h0002);
      acc(1'b1, ADDR_MODE_STAT, 16'h0002);
      rd(ADDR_MODE_STAT, 16'h0000);
    end
    $display("test reserved codes done");
    @(posedge mclk);
    fstart <= 1'b1;
    flen <= 8'd40 + 8'($urandom % 20);
    acc(1'b1, ADDR_CTRL_ONE, cr(3'b000, 3'b011, 3'b000));
    fstart <= 1'b0;
    repeat (14) @(posedge mclk);
    rd(ADDR_CTRL_ONE, cr(3'b000, 3'b011, cur));
    for (int k = 0; k < 200 && frame_active; k++) @(posedge mclk);
    // a frame that never ends counts as a mismatch and falls through to the report
    if (frame_active) begin
      miscompares++;
      $display("test busy bus timed out");
    end else begin
      repeat (16) @(posedge mclk);
      rd(ADDR_CTRL_ONE, cr(3'b000, 3'b011, 3'b011));
      `CHK("ctl", ctl_of(3'b011), ctl)
      $display("test busy bus done");
    end
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule // tb
bind mcr_mode_ctrl mcr_mode_ctrl_monitor mcr_mode_ctrl_monitor_inst (.mclk(mclk), .rst(rst),
  .bus(bus), .rdata(rdata), .frame_active(frame_active), .ctl(ctl));
